/* include/lbc_pkg.sv */
// constants, states and the reference table of the led boost sequencer
// assumes a 20 MHz system clock and a free-running oscillator clock
package lbc_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int STEP_TIME_US = 320;
	localparam int ILIM_LOW_TIME_MS = 5;
	localparam int PIN_LOW_SD_TIME_MS = 20;
	// least times round up to whole cycles
	localparam int STEP_CYC =
		(STEP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ILIM_LOW_CYC =
		(ILIM_LOW_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_LOW_SD_CYC =
		(PIN_LOW_SD_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// reference code and switching cycle
	// ----------------------------------------
	localparam int REF_CODE_W = 5;
	localparam int REF_MV_W = 8;
	localparam logic [REF_CODE_W-1:0] REF_CODE_ZERO = 5'h00;
	localparam logic [REF_CODE_W-1:0] REF_CODE_FULL = 5'h1f;
	localparam int OSC_CYC_LEN = 16;
	localparam int OSC_MAX_ON = 15;

	typedef enum logic [2:0] {
		LBC_IDLE,
		LBC_CHK_SHORT,
		LBC_CHK_SAFE,
		LBC_SHORT_HOLD,
		LBC_RUN
	} lbc_state_t;

	// reference code to millivolts
	function automatic logic [REF_MV_W-1:0] lbc_ref_mv(
		input logic [REF_CODE_W-1:0] code);
		logic [REF_MV_W-1:0] c;
		c = {3'h0, code};
		if (code == REF_CODE_ZERO) begin
			lbc_ref_mv = 8'h00;
		end else if (code <= 5'h0c) begin
			lbc_ref_mv = 8'h05 + 8'h03 * (c - 8'h01);
		end else if (code <= 5'h17) begin
			lbc_ref_mv = 8'h2c + 8'h06 * (c - 8'h0d);
		end else begin
			lbc_ref_mv = 8'h74 + 8'h0c * (c - 8'h18);
		end
	endfunction

endpackage

/* hdl/lbc_sync2.sv */
// two-flop level synchroniser
// assumes d comes from another clock domain or a pin
`timescale 1ns/100ps
module lbc_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

/* hdl/lbc_sequencer.sv */
// led boost control sequencer: start-up checks, soft start, dimming,
// shutdown timeout and per-cycle switch control
// assumes clk at 20 MHz, osc_clk free running, comparators asynchronous
`timescale 1ns/100ps
module lbc_sequencer
	import lbc_pkg::*;
#(
	parameter int STEP_CYCLES = lbc_pkg::STEP_CYC,
	parameter int ILIM_LOW_CYCLES = lbc_pkg::ILIM_LOW_CYC,
	parameter int PIN_LOW_SD_CYCLES = lbc_pkg::PIN_LOW_SD_CYC,
	parameter int CYC_LEN = lbc_pkg::OSC_CYC_LEN,
	parameter int MAX_ON = lbc_pkg::OSC_MAX_ON
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic osc_clk,
	input wire logic en_bit,
	input wire logic sync_mode,
	input wire logic dim_source_sel,
	input wire logic [lbc_pkg::REF_CODE_W-1:0] ref_level_code,
	input wire logic enable_dim_pin,
	input wire logic ovp_sense_low,
	input wire logic uvlo_fault,
	input wire logic ot_fault,
	input wire logic oc_fault,
	input wire logic overvoltage_protect,
	input wire logic pwm_cmp_trip,
	input wire logic ilim_norm_trip,
	input wire logic ilim_low_trip,
	output logic active_q,
	output logic ilim_low_q,
	output logic [lbc_pkg::REF_MV_W-1:0] ref_mv_q,
	output logic led_open_fault_q,
	output logic over_temp_fault_q,
	output logic out_short_fault_q,
	output logic low_side_switch_q,
	output logic rect_switch_q
);
	import lbc_pkg::*;

	localparam int STEP_W = $clog2(STEP_CYCLES + 1);
	localparam int ILIM_W = $clog2(ILIM_LOW_CYCLES + 1);
	localparam int SD_W = $clog2(PIN_LOW_SD_CYCLES + 1);
	localparam int CYC_W = $clog2(CYC_LEN + 1);

	// ----------------------------------------
	// pin synchronisers, system domain
	// ----------------------------------------
	logic pin_s, short_s, uvlo_s, ot_s, oc_s, ovp_s;

	lbc_sync2 #(.W(6)) u_sync_sys (
		.clk(clk),
		.rst_n(rst_n),
		.d({enable_dim_pin, ovp_sense_low, uvlo_fault, ot_fault,
			oc_fault, overvoltage_protect}),
		.q({pin_s, short_s, uvlo_s, ot_s, oc_s, ovp_s})
	);

	// ----------------------------------------
	// start-up sequencer
	// ----------------------------------------
	lbc_state_t state_q;
	logic [SD_W-1:0] low_cnt_q;
	logic pin_timeout;

	assign pin_timeout = low_cnt_q >= SD_W'(PIN_LOW_SD_CYCLES);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= LBC_IDLE;
		end else if (ce) begin
			unique case (state_q)
				LBC_IDLE: begin
					if (en_bit && pin_s) begin
						state_q <= LBC_CHK_SHORT;
					end
				end
				LBC_CHK_SHORT: begin
					if (!en_bit) begin
						state_q <= LBC_IDLE;
					end else if (short_s) begin
						state_q <= LBC_SHORT_HOLD;
					end else begin
						state_q <= LBC_CHK_SAFE;
					end
				end
				LBC_CHK_SAFE: begin
					if (!en_bit) begin
						state_q <= LBC_IDLE;
					end else if (!uvlo_s && !ot_s && !oc_s) begin
						state_q <= LBC_RUN;
					end
				end
				LBC_SHORT_HOLD: begin
					// disabled until the enable bit is cleared
					if (!en_bit) begin
						state_q <= LBC_IDLE;
					end
				end
				LBC_RUN: begin
					if (!en_bit || pin_timeout) begin
						state_q <= LBC_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// dimming pin low-time counter
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_cnt_q <= '0;
		end else if (ce) begin
			if (state_q != LBC_RUN || pin_s) begin
				low_cnt_q <= '0;
			end else if (!pin_timeout) begin
				low_cnt_q <= low_cnt_q + SD_W'(1);
			end
		end
	end

	// ----------------------------------------
	// reduced current limit window
	// ----------------------------------------
	logic [ILIM_W-1:0] ilim_cnt_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ilim_cnt_q <= '0;
			ilim_low_q <= 1'b1;
		end else if (ce) begin
			if (state_q == LBC_IDLE) begin
				ilim_cnt_q <= '0;
				ilim_low_q <= 1'b1;
			end else if (ilim_cnt_q < ILIM_W'(ILIM_LOW_CYCLES)) begin
				ilim_cnt_q <= ilim_cnt_q + ILIM_W'(1);
				ilim_low_q <= 1'b1;
			end else begin
				ilim_low_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// stepped reference slew
	// ----------------------------------------
	logic [REF_CODE_W-1:0] ref_idx_q, target;
	logic [STEP_W-1:0] step_cnt_q;

	// pwm-only dimming runs at full reference
	assign target = dim_source_sel ? REF_CODE_FULL : ref_level_code;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_idx_q <= REF_CODE_ZERO;
			step_cnt_q <= '0;
		end else if (ce) begin
			if (state_q != LBC_RUN) begin
				ref_idx_q <= REF_CODE_ZERO;
				step_cnt_q <= '0;
			end else if (ref_idx_q == target) begin
				step_cnt_q <= '0;
			end else if (step_cnt_q < STEP_W'(STEP_CYCLES - 1)) begin
				step_cnt_q <= step_cnt_q + STEP_W'(1);
			end else begin
				step_cnt_q <= '0;
				if (ref_idx_q < target) begin
					ref_idx_q <= ref_idx_q + REF_CODE_W'(1);
				end else begin
					ref_idx_q <= ref_idx_q - REF_CODE_W'(1);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_mv_q <= '0;
		end else if (ce) begin
			ref_mv_q <= lbc_ref_mv(ref_idx_q);
		end
	end

	// ----------------------------------------
	// fault indication and run gate
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_short_fault_q <= 1'b0;
		end else if (ce) begin
			if (state_q == LBC_CHK_SHORT && short_s) begin
				out_short_fault_q <= 1'b1;
			end else if (state_q == LBC_CHK_SHORT) begin
				out_short_fault_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			led_open_fault_q <= 1'b0;
			over_temp_fault_q <= 1'b0;
			active_q <= 1'b0;
		end else if (ce) begin
			led_open_fault_q <= ovp_s;
			over_temp_fault_q <= ot_s;
			// open string stops switching until vout falls
			active_q <= state_q == LBC_RUN && pin_s && !ovp_s
				&& !pin_timeout && en_bit;
		end
	end

	// ----------------------------------------
	// crossing into the oscillator domain
	// ----------------------------------------
	logic osc_rst_n, run_o, sync_o, ilim_low_o, ce_o;
	logic pwm_trip_o, inorm_o, ilow_o;

	lbc_sync2 #(.W(1)) u_sync_rst (
		.clk(osc_clk),
		.rst_n(1'b1),
		.d(rst_n),
		.q(osc_rst_n)
	);

	lbc_sync2 #(.W(7)) u_sync_osc (
		.clk(osc_clk),
		.rst_n(osc_rst_n),
		.d({active_q, sync_mode, ilim_low_q, ce, pwm_cmp_trip,
			ilim_norm_trip, ilim_low_trip}),
		.q({run_o, sync_o, ilim_low_o, ce_o, pwm_trip_o, inorm_o, ilow_o})
	);

	// ----------------------------------------
	// per-cycle switch control
	// ----------------------------------------
	logic [CYC_W-1:0] cyc_cnt_q;
	logic cyc_last, sw_trip;

	assign cyc_last = cyc_cnt_q == CYC_W'(CYC_LEN - 1);
	assign sw_trip = pwm_trip_o || (ilim_low_o ? ilow_o : inorm_o)
		|| cyc_cnt_q >= CYC_W'(MAX_ON - 1);

	always_ff @(posedge osc_clk) begin
		if (!osc_rst_n) begin
			cyc_cnt_q <= '0;
		end else if (ce_o) begin
			cyc_cnt_q <= cyc_last ? '0 : cyc_cnt_q + CYC_W'(1);
		end
	end

	always_ff @(posedge osc_clk) begin
		if (!osc_rst_n) begin
			low_side_switch_q <= 1'b0;
		end else if (ce_o) begin
			if (!run_o) begin
				low_side_switch_q <= 1'b0;
			end else if (cyc_last) begin
				low_side_switch_q <= 1'b1;
			end else if (sw_trip) begin
				low_side_switch_q <= 1'b0;
			end
		end
	end

	// rectifier conducts in the off time, turns off on the same edge as the next turn-on
	always_ff @(posedge osc_clk) begin
		if (!osc_rst_n) begin
			rect_switch_q <= 1'b0;
		end else if (ce_o) begin
			rect_switch_q <= run_o && sync_o && !cyc_last
				&& (!low_side_switch_q || sw_trip)
				&& cyc_cnt_q != CYC_W'(CYC_LEN - 1);
		end
	end
endmodule

/* tb/lbc_sequencer_checker.sv */
// port assertions for the led boost sequencer
// assumes binding to lbc_sequencer
`timescale 1ns/100ps
module lbc_sequencer_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic osc_clk,
	input wire logic en_bit,
	input wire logic sync_mode,
	input wire logic enable_dim_pin,
	input wire logic active_q,
	input wire logic ilim_low_q,
	input wire logic [lbc_pkg::REF_MV_W-1:0] ref_mv_q,
	input wire logic out_short_fault_q,
	input wire logic low_side_switch_q,
	input wire logic rect_switch_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_start_after_en: assert property ($rose(active_q) |->
		$past(en_bit, 3)) else $error("switching without enable");
	a_short_holds_off: assert property (out_short_fault_q |->
		!active_q) else $error("active with output short");
	a_en_clear_off: assert property (!en_bit |-> ##2 !active_q)
		else $error("active after enable cleared");
	a_ilim_low_idle: assert property (!en_bit[*4] |-> ilim_low_q)
		else $error("low limit not selected in idle");
	a_ref_idle_zero: assert property (!en_bit[*4] |->
		ref_mv_q == 8'h00) else $error("reference not restarted");
	a_ref_step_hold: assert property ($changed(ref_mv_q) &&
		ref_mv_q != 8'h00 |=> ($stable(ref_mv_q) || ref_mv_q == 8'h00)[*6])
		else $error("reference step too short");
	a_pin_low_off: assert property (!enable_dim_pin[*5] |->
		!active_q) else $error("active while pin low");
	a_async_rect_off: assert property (@(posedge osc_clk)
		disable iff (!rst_n) !sync_mode[*4] |-> !rect_switch_q)
		else $error("rectifier on in async mode");
	a_switch_on_bound: assert property (@(posedge osc_clk)
		disable iff (!rst_n) $rose(low_side_switch_q) |->
		##[1:15] !low_side_switch_q) else $error("switch on too long");
endmodule
bind lbc_sequencer lbc_sequencer_checker i_chk (.clk, .rst_n, .osc_clk,
	.en_bit, .sync_mode, .enable_dim_pin, .active_q, .ilim_low_q,
	.ref_mv_q, .out_short_fault_q, .low_side_switch_q, .rect_switch_q);

/* tb/lbc_dim_source.sv */
// dimming source on the enable pin: high, with single low pulses
// assumes go is a one-cycle request in the clk domain
`timescale 1ns/100ps
module lbc_dim_source (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] low_cyc,
	output logic pin
);
	logic [7:0] cnt_q;
	initial begin
		pin = 1'b1;
		cnt_q = 8'h00;
	end
	// low time set by caller; long only when asked
	always @(posedge clk) begin
		if (go) begin
			pin <= 1'b0;
			cnt_q <= low_cyc;
		end else if (cnt_q > 8'h01) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			pin <= 1'b1;
			cnt_q <= 8'h00;
		end
	end
endmodule

/* tb/test_lbc_sequencer.sv */
// self-checking bench for the led boost sequencer
// assumes checker and dimming source compiled first
`timescale 1ns/100ps
module test_lbc_sequencer;
	import lbc_pkg::*;
	logic clk, osc_clk, rst_n, en_bit, sync_mode, dim_source_sel, go;
	logic [REF_CODE_W-1:0] ref_level_code;
	logic [REF_MV_W-1:0] ref_mv_q;
	logic ovp_sense_low, uvlo_fault, ot_fault, oc_fault, pin, r, l;
	logic active_q, ilim_low_q, led_open_fault_q, over_temp_fault_q;
	logic out_short_fault_q, low_side_switch_q, rect_switch_q;
	logic [7:0] low_cyc;
	logic ce, ovp_hit, pwm_trip;
	int error_cnt, total_checks;
	lbc_sequencer #(.STEP_CYCLES(8), .ILIM_LOW_CYCLES(40),
		.PIN_LOW_SD_CYCLES(60)) i_dut (.clk, .rst_n, .ce, .osc_clk,
		.en_bit, .sync_mode, .dim_source_sel, .ref_level_code,
		.enable_dim_pin(pin), .ovp_sense_low, .uvlo_fault, .ot_fault,
		.oc_fault, .overvoltage_protect(ovp_hit), .pwm_cmp_trip(pwm_trip),
		.ilim_norm_trip(1'b0), .ilim_low_trip(1'b0), .active_q,
		.ilim_low_q, .ref_mv_q, .led_open_fault_q, .over_temp_fault_q,
		.out_short_fault_q, .low_side_switch_q, .rect_switch_q);
	lbc_dim_source i_src (.clk, .go, .low_cyc, .pin);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		osc_clk = 1'b0;
		#13;
		forever #80 osc_clk = ~osc_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task automatic put(input logic e, s, d, input logic [4:0] c);
		@(posedge clk);
		en_bit <= e;
		sync_mode <= s;
		dim_source_sel <= d;
		ref_level_code <= c;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_act(input logic v);
		for (int i = 0; i < 300 && active_q !== v; i++) tick(1);
		chb(active_q, v);
	endtask
	task automatic wait_ref(input logic [7:0] v);
		for (int i = 0; i < 20 && ref_mv_q !== v; i++) tick(1);
		chk(ref_mv_q, v);
	endtask
	task automatic osc_look(output logic rs, output logic ls);
		rs = 1'b0;
		ls = 1'b0;
		repeat (40) begin
			@(posedge osc_clk);
			#1;
			rs = rs | rect_switch_q;
			ls = ls | low_side_switch_q;
		end
	endtask
	task automatic pin_low(input logic [7:0] n);
		@(posedge clk);
		go <= 1'b1;
		low_cyc <= n;
		@(posedge clk);
		go <= 1'b0;
	endtask
	function automatic logic [7:0] mv(input int k);
		if (k == 0) return 8'h00;
		if (k < 13) return 8'(5 + 3 * (k - 1));
		if (k < 24) return 8'(44 + 6 * (k - 13));
		return 8'(116 + 12 * (k - 24));
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		{rst_n, en_bit, ovp_sense_low, go, dim_source_sel} = 5'h01;
		{sync_mode, uvlo_fault, ot_fault, oc_fault} = 4'hf;
		ref_level_code = 5'h00;
		low_cyc = 8'h00;
		{ce, ovp_hit, pwm_trip} = 3'h4;
		// osc side needs three of its edges in reset
		tick(14);
		rst_n <= 1'b1;
		tick(1);
		chb(ilim_low_q, 1'b1);
		chb(active_q, 1'b0);
		chk(ref_mv_q, 8'h00);
		put(1'b1, 1'b1, 1'b1, 5'h00);
		tick(10);
		chb(active_q, 1'b0);
		chb(over_temp_fault_q, 1'b1);
		ot_fault <= 1'b0;
		oc_fault <= 1'b0;
		tick(10);
		chb(active_q, 1'b0);
		uvlo_fault <= 1'b0;
		wait_act(1'b1);
		chb(ilim_low_q, 1'b1);
		chb(over_temp_fault_q, 1'b0);
		for (int k = 1; k < 32; k++) wait_ref(mv(k));
		chb(ilim_low_q, 1'b0);
		put(1'b1, 1'b1, 1'b0, 5'h1d);
		wait_ref(8'hbc);
		wait_ref(8'hb0);
		osc_look(r, l);
		chb(r, 1'b1);
		chb(l, 1'b1);
		put(1'b1, 1'b0, 1'b0, 5'h1d);
		tick(20);
		osc_look(r, l);
		chb(r, 1'b0);
		chb(l, 1'b1);
		pin_low(8'h14);
		tick(8);
		chb(active_q, 1'b0);
		wait_act(1'b1);
		chk(ref_mv_q, 8'hb0);
		pin_low(8'h50);
		tick(70);
		chk(ref_mv_q, 8'h00);
		chb(ilim_low_q, 1'b1);
		wait_act(1'b1);
		wait_ref(mv(1));
		ce <= 1'b0;
		tick(20);
		chk(ref_mv_q, mv(1));
		ce <= 1'b1;
		ovp_hit <= 1'b1;
		tick(6);
		chb(led_open_fault_q, 1'b1);
		chb(active_q, 1'b0);
		ovp_hit <= 1'b0;
		wait_act(1'b1);
		chb(led_open_fault_q, 1'b0);
		put(1'b0, 1'b0, 1'b0, 5'h1d);
		tick(4);
		chb(active_q, 1'b0);
		chk(ref_mv_q, 8'h00);
		ovp_sense_low <= 1'b1;
		put(1'b1, 1'b0, 1'b0, 5'h1d);
		tick(10);
		chb(out_short_fault_q, 1'b1);
		chb(active_q, 1'b0);
		tally_and_finish;
	end
endmodule
